// >>> core/fdos_map.svh
`ifndef FDOS_MAP_SVH
`define FDOS_MAP_SVH

// geometry
`define FDOS_NUM_CH        4
`define FDOS_NUM_PATH      8
`define FDOS_INT_W         8
`define FDOS_FRAC_W        43
`define FDOS_FRAC_HI_W     11
`define FDOS_ACC_W         56

// ahb address fields: haddr[7:6] channel, haddr[5:2] register index
`define FDOS_CH_LSB        6
`define FDOS_IDX_LSB       2
`define FDOS_UPPER_LSB     8

// register index within a channel window
`define FDOS_REG_INT       4'h0
`define FDOS_REG_FRAC_LO   4'h1
`define FDOS_REG_FRAC_HI   4'h2
`define FDOS_REG_FINE      4'h3
`define FDOS_REG_RATE      4'h4
`define FDOS_REG_STATUS    4'h5
`define FDOS_REG_DIV_A     4'h6
`define FDOS_REG_DUTY_A    4'h7
`define FDOS_REG_DIV_B     4'h8
`define FDOS_REG_DUTY_B    4'h9
`define FDOS_REG_PATH_CTRL 4'hA

// reset values
`define FDOS_RST_INT       8'h14
`define FDOS_RST_FRAC      43'h000_0000_0000
`define FDOS_RST_DIV       32'h0000_0002
`define FDOS_RST_DUTY      32'h0000_0000
`define FDOS_RST_INV       1'b1

// fraction denominator 2^43 at accumulator width
`define FDOS_UNIT          56'h00_0800_0000_0000

// ratio offsets and picoseconds retired per fod tick while steering
`define FDOS_DELTA_SLOW    56'h00_0001_0000_0000
`define FDOS_DELTA_MED     56'h00_0010_0000_0000
`define FDOS_DELTA_FAST    56'h00_0100_0000_0000
`define FDOS_STEP_SLOW     32'h0000_0001
`define FDOS_STEP_MED      32'h0000_0004
`define FDOS_STEP_FAST     32'h0000_0010

`endif

// >>> core/fdos_pkg.sv
package fdos_pkg;

  `include "fdos_map.svh"

  typedef enum logic [1:0] {
    FDOS_RATE_SLOW = 2'h0,
    FDOS_RATE_MED  = 2'h1,
    FDOS_RATE_FAST = 2'h2,
    FDOS_RATE_RSVD = 2'h3
  } fdos_rate_t;

  typedef enum logic [1:0] {
    FDOS_BUS_ADDR = 2'b01,
    FDOS_BUS_DATA = 2'b10
  } fdos_bus_st_t;

  typedef struct packed {
    logic [`FDOS_INT_W-1:0]  int_part;
    logic [`FDOS_FRAC_W-1:0] frac;
    fdos_rate_t              rate;
  } fdos_chan_cfg_t;

  typedef struct packed {
    logic [31:0] div;
    logic [31:0] duty;
    logic        comp_inv;
  } fdos_path_cfg_t;

endpackage

// >>> core/fdos_out_path.sv
`timescale 1ns/10ps

module fdos_out_path
  import fdos_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst,
  // fod clock as enable, configuration
  input  wire logic           fod_tick,
  input  wire fdos_path_cfg_t cfg,
  // pins
  output logic                true_out,
  output logic                comp_out
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] div_eff;
  logic [31:0] high_len;
  logic [32:0] cnt_inc;
  logic        hi_next;

  // divide by zero behaves as divide by one
  assign div_eff = (cfg.div == 32'h0000_0000) ? 32'h0000_0001 : cfg.div;
  assign cnt_inc = {1'b0, cnt_reg} + 33'h0_0000_0001;

  always_comb
  begin
    // zero width keeps the half/half clock
    if (cfg.duty == 32'h0000_0000) // RQ20
      high_len = 32'((({1'b0, div_eff} + 33'h0_0000_0001) >> 1)); // RQ15
    else
      high_len = cfg.duty; // RQ16
  end

  // a shrunk divider wraps at once instead of running to 2^32
  assign cnt_next = (cnt_inc >= {1'b0, div_eff}) ? 32'h0000_0000 : cnt_inc[31:0]; // RQ14

  // high for the first high_len fod cycles of each period, low after
  assign hi_next = fod_tick ? (cnt_next < high_len) : true_out; // RQ21

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= 32'h0000_0000;
    else if (fod_tick)
      cnt_reg <= cnt_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      true_out <= 1'b0;
      comp_out <= 1'b0;
    end
    else
    begin
      true_out <= hi_next; // RQ18
      comp_out <= cfg.comp_inv ? ~hi_next : hi_next; // RQ18
    end
  end

endmodule

// >>> core/fdos_top.sv
`timescale 1ns/10ps
`include "fdos_map.svh"

// Notes on behaviour
// RQ1: ratio is whole part plus 43-bit fraction.
// RQ2: host keeps ratio between 13.4 and 27.8.
// RQ3: each divider runs 500 MHz to 1 GHz.
// RQ4: each divider ratio set independently.
// RQ5: divider feeds output stage and loop feedback.
// RQ6: host avoids fractions near 0, 1, half.
// RQ7: signed picoseconds: negative advances, positive delays.
// RQ8: phase step by temporary frequency change.
// RQ9: fast, medium, slow shape step size/duration.
// RQ10: unlimited successive steps accumulate.
// RQ11: host steps only when divider is open loop.
// RQ12: stage n dual, fed by divider n.
// RQ13: both stage copies identical, same divider.
// RQ14: each path divides by 32-bit integer.
// RQ15: default output duty is half/half.
// RQ16: 32-bit high width counts fod cycles.
// RQ17: host keeps high width below divider.
// RQ18: pulses high-going; complement pin optionally inverted.
// RQ19: pulse width usable in every mode.
// RQ20: zero high width means half/half.
// RQ21: high for width, low for rest.

module fdos_top
  import fdos_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // output stage pins
  output logic [7:0]       true_output_pin,
  output logic [7:0]       complement_output_pin,
  // divider clocks toward the loop feedback dividers
  output logic [3:0]       fod_feedback_tick
);

  localparam int NCH = `FDOS_NUM_CH;
  localparam int NP  = `FDOS_NUM_PATH;

  function automatic logic [`FDOS_ACC_W-1:0] rate_delta(input fdos_rate_t r);
    unique case (r)
      FDOS_RATE_SLOW: rate_delta = `FDOS_DELTA_SLOW;
      FDOS_RATE_FAST: rate_delta = `FDOS_DELTA_FAST;
      default:        rate_delta = `FDOS_DELTA_MED;
    endcase
  endfunction

  function automatic logic [31:0] rate_step(input fdos_rate_t r);
    unique case (r)
      FDOS_RATE_SLOW: rate_step = `FDOS_STEP_SLOW;
      FDOS_RATE_FAST: rate_step = `FDOS_STEP_FAST;
      default:        rate_step = `FDOS_STEP_MED;
    endcase
  endfunction

  // path a of stage ch is 2*ch, path b is 2*ch+1
  function automatic logic [2:0] path_idx(input logic [1:0] ch, input logic b);
    path_idx = {ch, b};
  endfunction

  // configuration storage
  fdos_chan_cfg_t   chan_reg [NCH];
  fdos_path_cfg_t   path_reg [NP];
  logic signed [31:0] steer_rem_reg [NCH];
  logic [NCH-1:0]   fod_tick;

  // bus slave state
  fdos_bus_st_t     bus_st_reg;
  logic             wr_reg;
  logic [1:0]       ch_reg;
  logic [3:0]       idx_reg;
  logic             map_reg;
  logic             addr_take;
  logic             data_wr;
  logic [NCH-1:0]   fine_wr;
  logic [31:0]      rd_val;

  assign addr_take = hsel && htrans[1] && hready && (bus_st_reg == FDOS_BUS_ADDR);
  assign data_wr   = (bus_st_reg == FDOS_BUS_DATA) && wr_reg && map_reg;

  // one wait state per transfer keeps hrdata a registered output
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_st_reg <= FDOS_BUS_ADDR;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      wr_reg     <= 1'b0;
      ch_reg     <= 2'h0;
      idx_reg    <= 4'h0;
      map_reg    <= 1'b0;
    end
    else
    begin
      unique case (bus_st_reg)
        FDOS_BUS_ADDR:
        begin
          if (addr_take)
          begin
            bus_st_reg <= FDOS_BUS_DATA;
            hreadyout  <= 1'b0;
            wr_reg     <= hwrite;
            ch_reg     <= haddr[`FDOS_CH_LSB+1:`FDOS_CH_LSB];
            idx_reg    <= haddr[`FDOS_IDX_LSB+3:`FDOS_IDX_LSB];
            map_reg    <= (haddr[31:`FDOS_UPPER_LSB] == 24'h00_0000)
                          && (haddr[`FDOS_IDX_LSB+3:`FDOS_IDX_LSB] <= `FDOS_REG_PATH_CTRL);
          end
        end
        FDOS_BUS_DATA:
        begin
          bus_st_reg <= FDOS_BUS_ADDR;
          hreadyout  <= 1'b1;
          hrdata     <= (map_reg && !wr_reg) ? rd_val : 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // read side
  always_comb
  begin
    logic [2:0] pa;
    logic [2:0] pb;
    pa = path_idx(ch_reg, 1'b0);
    pb = path_idx(ch_reg, 1'b1);
    unique case (idx_reg)
      `FDOS_REG_INT:       rd_val = {24'h00_0000, chan_reg[ch_reg].int_part};
      `FDOS_REG_FRAC_LO:   rd_val = chan_reg[ch_reg].frac[31:0];
      `FDOS_REG_FRAC_HI:   rd_val = {21'h00_0000, chan_reg[ch_reg].frac[`FDOS_FRAC_W-1:32]};
      `FDOS_REG_FINE:      rd_val = steer_rem_reg[ch_reg];
      `FDOS_REG_RATE:      rd_val = {30'h0000_0000, chan_reg[ch_reg].rate};
      `FDOS_REG_STATUS:    rd_val = {30'h0000_0000, steer_rem_reg[ch_reg][31],
                                     (steer_rem_reg[ch_reg] != 32'sh0000_0000)};
      `FDOS_REG_DIV_A:     rd_val = path_reg[pa].div;
      `FDOS_REG_DUTY_A:    rd_val = path_reg[pa].duty;
      `FDOS_REG_DIV_B:     rd_val = path_reg[pb].div;
      `FDOS_REG_DUTY_B:    rd_val = path_reg[pb].duty;
      `FDOS_REG_PATH_CTRL: rd_val = {30'h0000_0000, path_reg[pb].comp_inv, path_reg[pa].comp_inv};
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // configuration writes, each channel independent of the others
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        chan_reg[c].int_part <= `FDOS_RST_INT;
        chan_reg[c].frac     <= `FDOS_RST_FRAC;
        chan_reg[c].rate     <= FDOS_RATE_MED;
      end
      for (int p = 0; p < NP; p++)
      begin
        path_reg[p].div      <= `FDOS_RST_DIV;
        path_reg[p].duty     <= `FDOS_RST_DUTY;
        path_reg[p].comp_inv <= `FDOS_RST_INV;
      end
    end
    else if (data_wr)
    begin
      unique case (idx_reg)
        `FDOS_REG_INT:       chan_reg[ch_reg].int_part <= hwdata[`FDOS_INT_W-1:0]; // RQ4
        `FDOS_REG_FRAC_LO:   chan_reg[ch_reg].frac[31:0] <= hwdata; // RQ1
        `FDOS_REG_FRAC_HI:   chan_reg[ch_reg].frac[`FDOS_FRAC_W-1:32] <= hwdata[`FDOS_FRAC_HI_W-1:0]; // RQ1
        `FDOS_REG_RATE:      chan_reg[ch_reg].rate <= fdos_rate_t'(hwdata[1:0]); // RQ9
        `FDOS_REG_DIV_A:     path_reg[path_idx(ch_reg, 1'b0)].div <= hwdata; // RQ14
        `FDOS_REG_DUTY_A:    path_reg[path_idx(ch_reg, 1'b0)].duty <= hwdata; // RQ19
        `FDOS_REG_DIV_B:     path_reg[path_idx(ch_reg, 1'b1)].div <= hwdata; // RQ14
        `FDOS_REG_DUTY_B:    path_reg[path_idx(ch_reg, 1'b1)].duty <= hwdata; // RQ19
        `FDOS_REG_PATH_CTRL:
        begin
          path_reg[path_idx(ch_reg, 1'b0)].comp_inv <= hwdata[0]; // RQ18
          path_reg[path_idx(ch_reg, 1'b1)].comp_inv <= hwdata[1]; // RQ18
        end
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      fine_wr[c] = data_wr && (idx_reg == `FDOS_REG_FINE) && (ch_reg == c[1:0]);
  end

  // fractional dividers; clk_sys stands in for the analog loop clock,
  // so a tick here models one fod cycle at f_sys/ratio
  for (genvar c = 0; c < NCH; c++)
  begin : g_fod
    logic [`FDOS_ACC_W-1:0] acc_reg;
    logic [`FDOS_ACC_W-1:0] acc_sum;
    logic [`FDOS_ACC_W-1:0] ratio_base;
    logic [`FDOS_ACC_W-1:0] ratio_eff;
    logic                   busy;
    logic                   tick;
    logic [31:0]            step;
    logic [31:0]            mag;
    logic signed [31:0]     dec;
    logic signed [31:0]     add;

    assign ratio_base = {5'h00, chan_reg[c].int_part, chan_reg[c].frac}; // RQ1
    assign busy       = (steer_rem_reg[c] != 32'sh0000_0000);

    // positive remainder delays: longer ratio, lower frequency
    always_comb
    begin
      if (!busy)
        ratio_eff = ratio_base;
      else if (!steer_rem_reg[c][31])
        ratio_eff = ratio_base + rate_delta(chan_reg[c].rate); // RQ8
      else
        ratio_eff = ratio_base - rate_delta(chan_reg[c].rate); // RQ8
    end

    // host keeps the ratio in range, which sets the 500 MHz to 1 GHz band
    assign acc_sum = acc_reg + `FDOS_UNIT; // RQ3
    assign tick    = (acc_sum >= ratio_eff);

    always_ff @(posedge clk_sys)
    begin
      if (rst)
        acc_reg <= '0;
      else
        acc_reg <= tick ? (acc_sum - ratio_eff) : acc_sum; // RQ1
    end

    // each tick retires a rate-dependent slice of the remaining step
    assign step = rate_step(chan_reg[c].rate); // RQ9
    assign mag  = steer_rem_reg[c][31] ? 32'(-steer_rem_reg[c]) : steer_rem_reg[c];
    always_comb
    begin
      if (!(tick && busy))
        dec = 32'sh0000_0000;
      else if (mag <= step)
        dec = steer_rem_reg[c];
      else if (steer_rem_reg[c][31])
        dec = -$signed(step);
      else
        dec = $signed(step);
    end
    // new steps add to whatever is still pending
    assign add = fine_wr[c] ? $signed(hwdata) : 32'sh0000_0000; // RQ10

    always_ff @(posedge clk_sys)
    begin
      if (rst)
        steer_rem_reg[c] <= 32'sh0000_0000;
      else
        steer_rem_reg[c] <= steer_rem_reg[c] - dec + add; // RQ7
    end

    assign fod_tick[c] = tick;
  end

  // loop feedback gets the same divider clock as the stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fod_feedback_tick <= 4'h0;
    else
      fod_feedback_tick <= fod_tick; // RQ5
  end

  // stage n is dual and fed only by divider n
  for (genvar p = 0; p < NP; p++)
  begin : g_path
    fdos_out_path u_path (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .fod_tick (fod_tick[p/2]), // RQ12 RQ13
      .cfg      (path_reg[p]),
      .true_out (true_output_pin[p]),
      .comp_out (complement_output_pin[p])
    );
  end

endmodule

// >>> sim/fdos_sva.sv
`timescale 1ns/10ps

module fdos_sva
  import fdos_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and divider ticks
  input wire logic [7:0]  true_output_pin,
  input wire logic [3:0]  fod_feedback_tick
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_TAKE_ANSWER: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("transfer not answered in two edges");
  AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("response not okay");
  AST_RDATA_HOLD: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside an answer");
  AST_FB_GAP0: assert property (fod_feedback_tick[0] |=> (!fod_feedback_tick[0]) [*8])
    else $error("divider 0 ticks too close");
  AST_FB_GAP1: assert property (fod_feedback_tick[1] |=> (!fod_feedback_tick[1]) [*8])
    else $error("divider 1 ticks too close");
  AST_PIN0_ON_TICK: assert property ($changed(true_output_pin[0]) |-> fod_feedback_tick[0])
    else $error("pin 0 moved off its divider tick");
  AST_PIN1_ON_TICK: assert property ($changed(true_output_pin[1]) |-> fod_feedback_tick[0])
    else $error("pin 1 moved off its divider tick");
  AST_PIN2_ON_TICK: assert property ($changed(true_output_pin[2]) |-> fod_feedback_tick[1])
    else $error("pin 2 moved off divider 1 tick");

  COV_READ: cover property ($rose(hreadyout) && hrdata != '0);
  COV_TICK1: cover property (fod_feedback_tick[1]);
  COV_PIN1: cover property ($rose(true_output_pin[1]));
endmodule

// >>> sim/fdos_sink.sv
`timescale 1ns/10ps

module fdos_sink (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst,
  // observed pin
  input  wire logic   pin,
  // lengths in clk_sys cycles
  output logic [31:0] hi_len,
  output logic [31:0] per_len
);
  logic        pin_reg;
  logic [31:0] cnt_reg;

  // lengths latch on edges only, a pin that stops toggling keeps stale values
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_reg <= 1'b0;
      cnt_reg <= '0;
      hi_len  <= '0;
      per_len <= '0;
    end
    else
    begin
      pin_reg <= pin;
      cnt_reg <= (pin && !pin_reg) ? 32'h0000_0001 : cnt_reg + 1;
      if (pin && !pin_reg)
        per_len <= cnt_reg;
      if (!pin && pin_reg)
        hi_len <= cnt_reg;
    end
  end
endmodule

// >>> sim/fdos_top_tb_top.sv
`timescale 1ns/10ps

module fdos_top_tb_top
  import fdos_pkg::*;
;
  `include "fdos_map.svh"
  // clocks per divider tick at the reset ratio of 20
  localparam int RT = 20;

  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = '0;
  logic [1:0]  htrans  = '0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = '0;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  true_output_pin;
  logic [7:0]  complement_output_pin;
  logic [3:0]  fod_feedback_tick;
  logic [31:0] hi_a, per_a, hi_b, per_b;
  int          bad_count = 0;
  int          checked   = 0;

  assign hready = hreadyout;
  always #2 clk_sys = ~clk_sys;

  fdos_top u_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .true_output_pin(true_output_pin),
    .complement_output_pin(complement_output_pin), .fod_feedback_tick(fod_feedback_tick));
  fdos_sink u_sink_a (.clk_sys(clk_sys), .rst(rst), .pin(true_output_pin[0]), .hi_len(hi_a), .per_len(per_a));
  fdos_sink u_sink_b (.clk_sys(clk_sys), .rst(rst), .pin(true_output_pin[1]), .hi_len(hi_b), .per_len(per_b));

  function automatic logic [31:0] ra(input int c, input logic [3:0] i);
    return {24'h00_0000, c[1:0], i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, '0, q);
    chk(nm, exp, q);
  endtask

  // polls busy; the count of polls stands in for the step's duration
  task automatic settle(input int c, output int n);
    logic [31:0] q;
    n = 0;
    do
    begin
      xfer(1'b0, ra(c, `FDOS_REG_STATUS), '0, q);
      n++;
    end
    while (q[0] === 1'b1 && n < 500);
    chk("settled", 32'h0000_0000, {31'h0000_0000, q[0]});
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    logic [31:0] q;
    int          dur [3];
    int          n0, n1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rc("int", ra(0, `FDOS_REG_INT), RT);
    rc("div_a", ra(3, `FDOS_REG_DIV_A), 2);
    rc("duty_b", ra(2, `FDOS_REG_DUTY_B), 0);
    rc("ctrl", ra(1, `FDOS_REG_PATH_CTRL), 3);
    rc("rate", ra(0, `FDOS_REG_RATE), 1);
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rc("unmapped", 32'h0000_0100, 0);
    repeat (200) @(posedge clk_sys);
    chk("hi_a", RT, hi_a);
    chk("per_a", 2 * RT, per_a);
    wr(ra(0, `FDOS_REG_DIV_A), 5);
    wr(ra(0, `FDOS_REG_DUTY_A), 2);
    wr(ra(0, `FDOS_REG_DIV_B), 5);
    wr(ra(0, `FDOS_REG_PATH_CTRL), 1);
    repeat (400) @(posedge clk_sys);
    chk("hi_a", 2 * RT, hi_a);
    chk("per_a", 5 * RT, per_a);
    chk("hi_b", 3 * RT, hi_b);
    chk("per_b", 5 * RT, per_b);
    repeat (8)
    begin
      repeat (7) @(posedge clk_sys);
      chk("comp_a", {31'h0000_0000, ~true_output_pin[0]}, {31'h0000_0000, complement_output_pin[0]});
      chk("comp_b", {31'h0000_0000, true_output_pin[1]}, {31'h0000_0000, complement_output_pin[1]});
      chk("comp_hi", {26'h000_0000, ~true_output_pin[7:2]}, {26'h000_0000, complement_output_pin[7:2]});
      chk("pairs", {29'h0000_0000, true_output_pin[6], true_output_pin[4], true_output_pin[2]},
          {29'h0000_0000, true_output_pin[7], true_output_pin[5], true_output_pin[3]});
    end
    wr(ra(1, `FDOS_REG_INT), 16);
    wr(ra(1, `FDOS_REG_FRAC_HI), 32'h0000_0200);
    repeat (100) @(posedge clk_sys);
    n0 = 0;
    n1 = 0;
    repeat (1300)
    begin
      @(posedge clk_sys);
      n0 += int'(fod_feedback_tick[0]);
      n1 += int'(fod_feedback_tick[1]);
    end
    chk("ticks0", 65, n0);
    chk("ticks1", 80, n1);
    for (int r = 2; r >= 0; r--)
    begin
      wr(ra(2, `FDOS_REG_RATE), r);
      wr(ra(2, `FDOS_REG_FINE), 32);
      rc("dir_delay", ra(2, `FDOS_REG_STATUS), 1);
      settle(2, dur[r]);
    end
    chk("fast_short", 1, {31'h0000_0000, dur[2] < dur[1]});
    chk("slow_long", 1, {31'h0000_0000, dur[1] < dur[0]});
    wr(ra(2, `FDOS_REG_FINE), 32'hFFFF_FFE0);
    wr(ra(2, `FDOS_REG_FINE), 32'hFFFF_FFE0);
    rc("dir_adv", ra(2, `FDOS_REG_STATUS), 3);
    xfer(1'b0, ra(2, `FDOS_REG_FINE), '0, q);
    chk("accum", 1, {31'h0000_0000, $signed(q) < -32});
    wr(ra(2, `FDOS_REG_RATE), 2);
    settle(2, n0);
    rc("fine_done", ra(2, `FDOS_REG_FINE), 0);
    conclude;
  end

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    conclude;
  end
endmodule

bind fdos_top fdos_sva u_sva (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .true_output_pin(true_output_pin),
  .fod_feedback_tick(fod_feedback_tick));
